//--- include/imu_regs_defs.vh
// Register map, field layout, reset values and timing for the IMU slice
`ifndef IMU_REGS_DEFS_VH
`define IMU_REGS_DEFS_VH

`define ADDR_ERR 8'h02
`define ADDR_TEMP_LO 8'h20
`define ADDR_TEMP_HI 8'h21
`define ADDR_FILL_LO 8'h22
`define ADDR_FILL_HI 8'h23
`define ADDR_QPORT 8'h24
`define ADDR_ACCEL_CONFIGURATION 8'h40
`define ADDR_FIFO_CFG0 8'h46
`define ADDR_FIFO_CFG1 8'h47
`define ADDR_INT_STAT 8'h50
`define ADDR_INT_EN 8'h51
`define ADDR_INT_CLR 8'h52
`define ADDR_CMD 8'h7E

`define ACCEL_UNDERSAMPLE_FLAG_BIT 7
`define ACC_BWP_HI 6
`define ACC_BWP_LO 4
`define ACC_ODR_HI 3
`define ACC_ODR_LO 0
`define ACCEL_CONFIGURATION_RST 8'h28
`define FIFO_CFG_RST 8'h00
`define ACC_ODR_MIN 4'h1
`define ACC_ODR_MAX 4'hC
`define ACC_BWP_MAX_FILT 3'h2

`define ERR_CODE_LSB 1
`define ERR_CODE_ACC 4'h1

`define TEMP_ZERO 16'h0000
`define TEMP_INVALID 16'h8000

`define CMD_FIFO_FLUSH 8'hB0
`define CMD_ACC_SUSPEND 8'h10
`define CMD_ACC_NORMAL 8'h11
`define CMD_ACC_LOWPWR 8'h12

`define PMU_SUSPEND 2'b00
`define PMU_NORMAL 2'b01
`define PMU_LOWPWR 2'b10
`define PMU_FASTUP 2'b11

`define IRQ_TEMP 0
`define IRQ_FRAME 1
`define IRQ_ERR 2
`define IRQ_W 3

`define CLK_PERIOD_NS 25
`define TEMP_FAST_MS 10
`define TEMP_SLOW_MS 1280
`define NS_PER_MS 1000000
// Refresh periods in clock cycles: 10 ms and 1.28 s at a 25 ns clock
`define TEMP_FAST_CNT 26'h006_1a80
`define TEMP_SLOW_CNT 26'h30d_4000

`endif

//--- src/frame_tracker.v
// Byte position inside the head frame of the queue during burst readout
`default_nettype none

module frame_tracker
(
    input wire i_sys_clk,
    input wire i_rst_b,
    input wire i_rd_port,
    input wire i_burst_end,
    input wire i_flush,
    input wire [3:0] i_head_len,
    output wire [3:0] o_byte_idx,
    output wire o_frame_done
);

reg [3:0] idx_r;
reg [3:0] idx_nxt;
wire last_byte;

// A zero length is taken as one byte so the index can never run away
assign last_byte = (i_head_len == 4'h0) ? 1'b1 :
                   (idx_r == i_head_len - 4'h1);
assign o_frame_done = i_rd_port & last_byte; // RQ9
// Next index, so that a registered copy names the byte the next read takes
assign o_byte_idx = idx_nxt;

always @*
begin
    idx_nxt = idx_r;
    if (i_flush)
        idx_nxt = 4'h0;
    else if (o_frame_done)
        idx_nxt = 4'h0;
    else if (i_burst_end)
        // Partial frame: restart at the header on the next readout
        idx_nxt = 4'h0; // RQ11
    else if (i_rd_port)
        idx_nxt = idx_r + 4'h1;
end

always @(posedge i_sys_clk or negedge i_rst_b)
begin
    if (!i_rst_b)
        idx_r <= 4'h0;
    else
        idx_r <= idx_nxt;
end

endmodule

`default_nettype wire

//--- src/imu_readout_config_regs.v
// Temperature, queue readout and accelerometer setup register slice
//
// Our own choice: strobed register access.
`default_nettype none
`include "imu_regs_defs.vh"

// Function
// RQ1: Read-only 16-bit die temperature word at 0x20.
// RQ2: Temperature measurement is off while every sensor is suspended.
// RQ3: Temperature counts as valid only while the gyro reports normal mode.
// RQ4: Signed word, zero is 23 C, 0x8000 marks an invalid reading.
// RQ5: Gyro normal: temperature refreshed every 10 ms.
// RQ6: Gyro suspended or fast power-up: refreshed every 1.28 s.
// RQ7: Read-only queue fill level in bytes, zero when empty.
// RQ8: Fill level clears when fully drained or on a flush command.
// RQ9: Fill level changes only when a whole frame is read or written.
// RQ10: Host bursts at 0x24; the readout address never increments.
// RQ11: A partly read frame is resent whole, header first.
// RQ12: Readout bytes follow the queue configuration registers.
// RQ13: Accel setup byte resets to 0x28; flag bit 7, bandwidth bits 6:4.
// RQ14: Rate code 100/2^(8-code) Hz; 0 and 13-15 reserved.
// RQ15: Bandwidth means filter without undersampling, averaging with it.
// RQ16: Clearing undersampling moves a low-power accel to normal mode.
// RQ17: Low-power command ignored while undersampling is cleared.
// RQ18: A setup lacking a defined bandwidth records an error code.
module imu_readout_config_regs
#(
    parameter [25:0] TEMP_FAST_CYC = `TEMP_FAST_CNT,
    parameter [25:0] TEMP_SLOW_CYC = `TEMP_SLOW_CNT
)
(
    input wire i_sys_clk,
    input wire i_rst_b,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire i_burst_end,
    input wire [15:0] i_temp_sample,
    input wire [1:0] i_gyr_pmu_status,
    input wire i_mag_suspend,
    input wire i_frame_wr,
    input wire [3:0] i_frame_wr_len,
    input wire [3:0] i_head_len,
    input wire [7:0] i_queue_byte,
    output reg [7:0] o_rdata,
    output reg o_irq,
    output reg [1:0] o_acc_pmu_mode,
    output reg [7:0] o_accel_setup_reg,
    output reg [2:0] o_acc_filter_sel,
    output reg [2:0] o_acc_avg_sel,
    output reg o_temp_valid,
    output reg o_queue_flush,
    output reg o_frame_pop,
    output reg [3:0] o_byte_idx,
    output reg [15:0] o_queue_config
);

// Reserved rate codes and a filter-mode bandwidth beyond the table
function conf_illegal;
    input [7:0] conf;
    reg [3:0] odr;
    reg [2:0] bwp;
    begin
        odr = conf[`ACC_ODR_HI:`ACC_ODR_LO];
        bwp = conf[`ACC_BWP_HI:`ACC_BWP_LO];
        conf_illegal = (odr < `ACC_ODR_MIN) || (odr > `ACC_ODR_MAX) ||
            (!conf[`ACCEL_UNDERSAMPLE_FLAG_BIT] && (bwp > `ACC_BWP_MAX_FILT));
    end
endfunction

// Strobe qualified by one register address; shared by every strobe decode
function reg_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
        reg_hit = strobe && (addr == target);
    end
endfunction

reg [15:0] temp_r;
reg [15:0] temp_nxt;
reg [25:0] tcnt_r;
reg [25:0] tcnt_nxt;
reg [10:0] fill_r;
reg [10:0] fill_nxt;
reg [7:0] accel_configuration_r;
reg [7:0] accel_configuration_nxt;
reg [1:0] acc_pmu_r;
reg [1:0] acc_pmu_nxt;
reg [7:0] qcfg0_r;
reg [7:0] qcfg1_r;
reg [7:0] err_r;
reg [7:0] err_nxt;
reg [`IRQ_W-1:0] int_en_r;
reg [`IRQ_W-1:0] int_stat_r;
reg [`IRQ_W-1:0] int_stat_nxt;
reg [7:0] rdata_nxt;
reg temp_tick;
wire [`IRQ_W-1:0] int_event;
wire [`IRQ_W-1:0] int_clear;
wire all_suspend;
wire gyr_normal;
wire queue_empty;
wire rd_port;
wire frame_done;
wire [3:0] byte_idx;
wire cmd_wr;
wire flush_cmd;
wire conf_wr;
wire conf_bad;
wire [25:0] temp_limit;
wire [2:0] bwp_field;
wire err_rd;
wire qcfg0_wr;
wire qcfg1_wr;
wire en_wr;
wire clr_wr;

assign gyr_normal = (i_gyr_pmu_status == `PMU_NORMAL);
assign all_suspend = (acc_pmu_r == `PMU_SUSPEND) &&
                     (i_gyr_pmu_status == `PMU_SUSPEND) && i_mag_suspend;
assign queue_empty = (fill_r == 11'h000);
// The port address is held for the whole burst, so every read of a non-empty queue advances
assign rd_port = reg_hit(i_rd, i_addr, `ADDR_QPORT) && !queue_empty; // RQ10
assign cmd_wr = reg_hit(i_wr, i_addr, `ADDR_CMD);
assign flush_cmd = cmd_wr && (i_wdata == `CMD_FIFO_FLUSH);
assign conf_wr = reg_hit(i_wr, i_addr, `ADDR_ACCEL_CONFIGURATION);
assign conf_bad = conf_wr && conf_illegal(i_wdata); // RQ18
// Setup field as it stands after this edge, for the output flops
assign bwp_field = accel_configuration_nxt[`ACC_BWP_HI:`ACC_BWP_LO];

// Register strobes
assign err_rd = reg_hit(i_rd, i_addr, `ADDR_ERR);
assign qcfg0_wr = reg_hit(i_wr, i_addr, `ADDR_FIFO_CFG0);
assign qcfg1_wr = reg_hit(i_wr, i_addr, `ADDR_FIFO_CFG1);
assign en_wr = reg_hit(i_wr, i_addr, `ADDR_INT_EN);
assign clr_wr = reg_hit(i_wr, i_addr, `ADDR_INT_CLR);

frame_tracker u_frame_tracker
(
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_rd_port(rd_port),
    .i_burst_end(i_burst_end),
    .i_flush(flush_cmd),
    .i_head_len(i_head_len),
    .o_byte_idx(byte_idx),
    .o_frame_done(frame_done)
);

// Temperature refresh timer
// The tick falls on the last count, so a period is exactly the limit
assign temp_limit = gyr_normal ? TEMP_FAST_CYC : TEMP_SLOW_CYC; // RQ5 RQ6

always @*
begin
    tcnt_nxt = tcnt_r + 26'h000_0001;
    temp_tick = 1'b0;
    temp_nxt = temp_r;
    if (all_suspend)
    begin
        // Measurement stops; the word reads as invalid until the first refresh after resuming
        tcnt_nxt = 26'h000_0000;
        temp_nxt = `TEMP_INVALID; // RQ2
    end
    else if (tcnt_r >= temp_limit - 26'h000_0001)
    begin
        tcnt_nxt = 26'h000_0000;
        temp_tick = 1'b1;
        // Sample is already signed, zero at 23 C, 2^-9 K per step
        temp_nxt = i_temp_sample; // RQ4 RQ5 RQ6
    end
end

// Fill level moves in whole frames only
always @*
begin
    fill_nxt = fill_r;
    if (flush_cmd)
        fill_nxt = 11'h000; // RQ8
    else
    begin
        if (i_frame_wr)
            fill_nxt = fill_nxt + {7'h00, i_frame_wr_len}; // RQ7 RQ9
        if (frame_done)
            fill_nxt = fill_nxt - {7'h00, i_head_len}; // RQ8 RQ9
    end
end

// Accelerometer setup and power mode
always @*
begin
    accel_configuration_nxt = accel_configuration_r;
    acc_pmu_nxt = acc_pmu_r;
    if (conf_wr)
        accel_configuration_nxt = i_wdata; // RQ13 RQ14
    if (cmd_wr)
    begin
        case (i_wdata)
            `CMD_ACC_SUSPEND: acc_pmu_nxt = `PMU_SUSPEND;
            `CMD_ACC_NORMAL: acc_pmu_nxt = `PMU_NORMAL;
            `CMD_ACC_LOWPWR:
                if (accel_configuration_r[`ACCEL_UNDERSAMPLE_FLAG_BIT])
                    acc_pmu_nxt = `PMU_LOWPWR; // RQ17
            default: acc_pmu_nxt = acc_pmu_r;
        endcase
    end
    // Low power without undersampling cannot stand; fall back to normal
    if (!accel_configuration_nxt[`ACCEL_UNDERSAMPLE_FLAG_BIT] && (acc_pmu_nxt == `PMU_LOWPWR))
        acc_pmu_nxt = `PMU_NORMAL; // RQ16
end

// Error register: sticky code, cleared by reading it, a new error wins
always @*
begin
    err_nxt = err_r;
    if (err_rd)
        err_nxt = 8'h00;
    if (conf_bad)
        err_nxt[`ERR_CODE_LSB+3:`ERR_CODE_LSB] = `ERR_CODE_ACC; // RQ18
end

// Sticky interrupt status; a set in the clearing cycle survives
assign int_event[`IRQ_TEMP] = temp_tick;
assign int_event[`IRQ_FRAME] = frame_done;
assign int_event[`IRQ_ERR] = conf_bad;
assign int_clear = clr_wr ?
                   i_wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

genvar g;
generate
    for (g = 0; g < `IRQ_W; g = g + 1)
    begin : g_stat
        always @*
        begin
            int_stat_nxt[g] = int_event[g] |
                              (int_stat_r[g] & ~int_clear[g]);
        end
    end
endgenerate

// Read mux; data appear in the cycle after the strobe
always @*
begin
    rdata_nxt = 8'h00;
    if (i_rd)
    begin
        case (i_addr)
            `ADDR_ERR: rdata_nxt = err_r;
            `ADDR_TEMP_LO: rdata_nxt = temp_r[7:0]; // RQ1
            `ADDR_TEMP_HI: rdata_nxt = temp_r[15:8]; // RQ1
            `ADDR_FILL_LO: rdata_nxt = fill_r[7:0]; // RQ7
            `ADDR_FILL_HI: rdata_nxt = {5'h00, fill_r[10:8]}; // RQ7
            // Byte already laid out by the queue per its configuration
            `ADDR_QPORT:
                rdata_nxt = queue_empty ? 8'h00 : i_queue_byte; // RQ12
            `ADDR_ACCEL_CONFIGURATION: rdata_nxt = accel_configuration_r; // RQ13
            `ADDR_FIFO_CFG0: rdata_nxt = qcfg0_r;
            `ADDR_FIFO_CFG1: rdata_nxt = qcfg1_r;
            `ADDR_INT_STAT: rdata_nxt = {5'h00, int_stat_r};
            `ADDR_INT_EN: rdata_nxt = {5'h00, int_en_r};
            default: rdata_nxt = 8'h00;
        endcase
    end
end

always @(posedge i_sys_clk or negedge i_rst_b)
begin
    if (!i_rst_b)
    begin
        temp_r <= `TEMP_INVALID;
        tcnt_r <= 26'h000_0000;
        fill_r <= 11'h000;
        accel_configuration_r <= `ACCEL_CONFIGURATION_RST;
        acc_pmu_r <= `PMU_SUSPEND;
        qcfg0_r <= `FIFO_CFG_RST;
        qcfg1_r <= `FIFO_CFG_RST;
        err_r <= 8'h00;
        int_en_r <= {`IRQ_W{1'b0}};
        int_stat_r <= {`IRQ_W{1'b0}};
    end
    else
    begin
        temp_r <= temp_nxt;
        tcnt_r <= tcnt_nxt;
        fill_r <= fill_nxt;
        accel_configuration_r <= accel_configuration_nxt;
        acc_pmu_r <= acc_pmu_nxt;
        if (qcfg0_wr)
            qcfg0_r <= i_wdata; // RQ12
        if (qcfg1_wr)
            qcfg1_r <= i_wdata; // RQ12
        err_r <= err_nxt;
        if (en_wr)
            int_en_r <= i_wdata[`IRQ_W-1:0];
        int_stat_r <= int_stat_nxt;
    end
end

// Output flops
always @(posedge i_sys_clk or negedge i_rst_b)
begin
    if (!i_rst_b)
    begin
        o_rdata <= 8'h00;
        o_irq <= 1'b0;
        o_acc_pmu_mode <= `PMU_SUSPEND;
        o_accel_setup_reg <= `ACCEL_CONFIGURATION_RST;
        o_acc_filter_sel <= 3'h0;
        o_acc_avg_sel <= 3'h0;
        o_temp_valid <= 1'b0;
        o_queue_flush <= 1'b0;
        o_frame_pop <= 1'b0;
        o_byte_idx <= 4'h0;
        o_queue_config <= {`FIFO_CFG_RST, `FIFO_CFG_RST};
    end
    else
    begin
        o_rdata <= rdata_nxt;
        o_irq <= |(int_stat_nxt & int_en_r);
        o_acc_pmu_mode <= acc_pmu_nxt;
        o_accel_setup_reg <= accel_configuration_nxt;
        // Only one reading of the bandwidth field is active at a time
        if (accel_configuration_nxt[`ACCEL_UNDERSAMPLE_FLAG_BIT])
        begin
            o_acc_filter_sel <= 3'h0;
            o_acc_avg_sel <= bwp_field; // RQ15
        end
        else
        begin
            o_acc_filter_sel <= bwp_field; // RQ15
            o_acc_avg_sel <= 3'h0;
        end
        o_temp_valid <= gyr_normal && !all_suspend; // RQ3
        o_queue_flush <= flush_cmd; // RQ8
        o_frame_pop <= frame_done;
        // The queue looks its byte up from this index without a register,
        // so it must name the byte that the next read takes
        o_byte_idx <= flush_cmd ? 4'h0 : byte_idx; // RQ11
        o_queue_config <= {qcfg1_r, qcfg0_r};
    end
end

endmodule

`default_nettype wire

//--- verification/imu_regs_assertions.sv
// Assertions on the ports of the IMU register slice
`default_nettype none
module imu_regs_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [1:0] i_gyr_pmu_status,
    input wire logic [7:0] o_rdata,
    input wire logic [1:0] o_acc_pmu_mode,
    input wire logic [7:0] o_accel_setup_reg,
    input wire logic [2:0] o_acc_filter_sel,
    input wire logic [2:0] o_acc_avg_sel,
    input wire logic o_temp_valid,
    input wire logic o_queue_flush,
    input wire logic o_frame_pop
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);
    wire setup_wr = i_wr && i_addr == 8'h40;
    wire cmd_wr = i_wr && i_addr == 8'h7e;
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_setup_write: assert property (setup_wr |=>
        o_accel_setup_reg == $past(i_wdata))
        else $error("setup byte not stored");
    a_bw_meaning: assert property (setup_wr |=>
        {o_acc_filter_sel, o_acc_avg_sel} == (o_accel_setup_reg[7] ?
        {3'h0, o_accel_setup_reg[6:4]} : {o_accel_setup_reg[6:4], 3'h0}))
        else $error("bandwidth field routed wrongly");
    a_us_clear: assert property (setup_wr && !i_wdata[7] &&
        o_acc_pmu_mode == 2'b10 |=> o_acc_pmu_mode == 2'b01)
        else $error("low power kept after undersampling cleared");
    a_lowpwr_block: assert property (cmd_wr && i_wdata == 8'h12 &&
        !o_accel_setup_reg[7] |=> $stable(o_acc_pmu_mode))
        else $error("low power command taken without undersampling");
    a_flush_pulse: assert property (cmd_wr && i_wdata == 8'hb0 |=>
        o_queue_flush ##1 !o_queue_flush)
        else $error("flush pulse missing or too long");
    a_temp_valid: assert property (o_temp_valid |->
        $past(i_gyr_pmu_status) == 2'b01)
        else $error("temperature valid outside gyro normal mode");
    a_pop_cause: assert property (o_frame_pop |->
        $past(i_rd) && $past(i_addr) == 8'h24)
        else $error("frame pop without a readout port read");
endmodule
`default_nettype wire

//--- verification/queue_model.sv
// Queue stand-in: three-byte frames tagged with frame number and index
`default_nettype none
module queue_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_push,
    input wire logic i_frame_pop,
    input wire logic [3:0] i_byte_idx,
    output logic o_frame_wr,
    output logic [3:0] o_len,
    output logic [7:0] o_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] head_r;
    assign o_len = 4'h3;
    // Frame number and index in each byte show whether a resend starts at the header
    assign o_byte = {head_r, i_byte_idx};
    always @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            head_r <= 4'h0;
            o_frame_wr <= 1'b0;
        end
        else
        begin
            o_frame_wr <= i_push;
            head_r <= head_r + {3'h0, i_frame_pop};
        end
    end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the IMU register slice
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, bend = 1'b0;
    logic msus = 1'b0, push = 1'b0, irq, tval, flush, pop, fwr;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, setup, qbyte, d;
    logic [15:0] ts = 16'h0000, s1, qcfg;
    logic [1:0] gyr = 2'b01, pmu;
    logic [2:0] fsel, asel;
    logic [3:0] len, idx;
    integer seed = 32'h754f_243f, err_count = 0, n_tests = 0;
    logic [7:0] tbl [0:3] = '{8'h80, 8'h0d, 8'h38, 8'hb8};
    logic [23:0] pm [0:5] = '{24'h7e_1101, 24'h40_8801, 24'h7e_1202,
        24'h40_2801, 24'h7e_1201, 24'h7e_1000};
    imu_readout_config_regs #(.TEMP_FAST_CYC(26'h14), .TEMP_SLOW_CYC(26'h3c))
        uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr(wr),
        .i_wdata(wdata), .i_rd(rd), .i_burst_end(bend), .i_temp_sample(ts),
        .i_gyr_pmu_status(gyr), .i_mag_suspend(msus), .i_frame_wr(fwr),
        .i_frame_wr_len(len), .i_head_len(len), .i_queue_byte(qbyte),
        .o_rdata(rdata), .o_irq(irq), .o_acc_pmu_mode(pmu),
        .o_accel_setup_reg(setup), .o_acc_filter_sel(fsel),
        .o_acc_avg_sel(asel), .o_temp_valid(tval), .o_queue_flush(flush),
        .o_frame_pop(pop), .o_byte_idx(idx), .o_queue_config(qcfg));
    queue_model q (.i_sys_clk(clk), .i_rst_b(rst_b), .i_push(push),
        .i_frame_pop(pop), .i_byte_idx(idx), .o_frame_wr(fwr), .o_len(len),
        .o_byte(qbyte));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [7:0] exp_err(input logic [7:0] c);
        exp_err = (c[3:0] == 4'h0 || c[3:0] > 4'hc || (!c[7] && c[6:4] > 3'h2))
            ? 8'h02 : 8'h00;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rc(input logic [7:0] a, e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic push1;
        @(posedge clk);
        push <= 1'b1;
        @(posedge clk);
        push <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic burst(input int n, input logic [3:0] f);
        @(posedge clk);
        addr <= 8'h24;
        rd <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            if (i == n - 1)
                rd <= 1'b0;
            #1 chk("queue byte", {8'h00, f, i[3:0]}, {8'h00, rdata});
        end
        @(posedge clk);
        bend <= 1'b1;
        @(posedge clk);
        bend <= 1'b0;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rc(8'h40, 8'h28);
        rc(8'h20, 8'h00);
        rc(8'h21, 8'h80);
        rc(8'h24, 8'h00);
        rc(8'h30, 8'h00);
        s1 = 16'($random(seed));
        ts <= s1;
        repeat (30) @(posedge clk);
        rc(8'h20, s1[7:0]);
        rc(8'h21, s1[15:8]);
        chk("temp valid", 16'h0001, {15'h0000, tval});
        gyr <= 2'b11;
        repeat (2) @(posedge clk);
        ts <= ~s1;
        repeat (10) @(posedge clk);
        rc(8'h20, s1[7:0]);
        chk("temp valid", 16'h0000, {15'h0000, tval});
        repeat (70) @(posedge clk);
        rc(8'h21, ~s1[15:8]);
        gyr <= 2'b00;
        msus <= 1'b1;
        wreg(8'h20, 8'h55);
        rc(8'h21, 8'h80);
        $display("test temperature done");
        for (int i = 0; i < 12; i++)
        begin
            d = (i < 4) ? tbl[i] : 8'($random(seed));
            wreg(8'h40, d);
            rc(8'h40, d);
            chk("bw sel", {10'h000, d[7] ? {3'h0, d[6:4]} : {d[6:4], 3'h0}},
                {10'h000, fsel, asel});
            rc(8'h02, exp_err(d));
        end
        for (int i = 0; i < 6; i++)
        begin
            wreg(pm[i][23:16], pm[i][15:8]);
            chk("pmu", {14'h0000, pm[i][1:0]}, {14'h0000, pmu});
        end
        $display("test setup done");
        push1;
        push1;
        rc(8'h22, 8'h06);
        burst(2, 4'h0);
        rc(8'h22, 8'h06);
        burst(3, 4'h0);
        rc(8'h22, 8'h03);
        burst(3, 4'h1);
        rc(8'h22, 8'h00);
        wreg(8'h51, 8'h02);
        repeat (2) @(negedge clk);
        chk("irq", 16'h0001, {15'h0000, irq});
        wreg(8'h52, 8'h02);
        repeat (2) @(negedge clk);
        chk("irq", 16'h0000, {15'h0000, irq});
        push1;
        rc(8'h22, 8'h03);
        wreg(8'h7e, 8'hb0);
        rc(8'h22, 8'h00);
        s1 = 16'($random(seed));
        wreg(8'h46, s1[7:0]);
        wreg(8'h47, s1[15:8]);
        rc(8'h47, s1[15:8]);
        chk("queue config", s1, qcfg);
        $display("test queue done");
        final_report;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report;
    end
endmodule
bind imu_readout_config_regs imu_regs_checker chk_u (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_gyr_pmu_status(i_gyr_pmu_status), .o_rdata(o_rdata),
    .o_acc_pmu_mode(o_acc_pmu_mode), .o_accel_setup_reg(o_accel_setup_reg),
    .o_acc_filter_sel(o_acc_filter_sel), .o_acc_avg_sel(o_acc_avg_sel),
    .o_temp_valid(o_temp_valid), .o_queue_flush(o_queue_flush),
    .o_frame_pop(o_frame_pop));
`default_nettype wire
